// ### canopen_guard_pkg.sv
// constants for the node guarding, heartbeat and pdo block
// assumes a frame-level can controller on the same 40 MHz clock
package canopen_guard_pkg;
   localparam int unsigned   CLK_PERIOD_NS = 25;
   localparam int unsigned   TICK_MS_NS    = 1000000;
   localparam int unsigned   MS_CYCLES     = TICK_MS_NS / CLK_PERIOD_NS;
   localparam int            ID_W          = 11;
   localparam logic [10:0]   ID_NMT        = 11'h000;
   localparam logic [10:0]   ID_EMCY_BASE  = 11'h080;
   localparam logic [10:0]   ID_GUARD_BASE = 11'h700;
   localparam logic [15:0]   IDX_GUARD     = 16'h100C;
   localparam logic [15:0]   IDX_LIFE      = 16'h100D;
   localparam logic [15:0]   IDX_ERR_REG   = 16'h1001;
   localparam logic [15:0]   IDX_HEARTBEAT = 16'h1017;
   localparam logic [15:0]   IDX_RPDO      = 16'h1400;
   localparam logic [15:0]   IDX_TPDO      = 16'h1800;
   localparam logic [7:0]    SUB_COBID     = 8'h01;
   localparam logic [7:0]    SUB_EVTIMER   = 8'h05;
   localparam int            COB_VALID_BIT = 31;
   localparam int            COB_EXT_BIT   = 29;
   localparam logic [31:0]   COB_RESET     = 32'h8000_0000;
   localparam logic [6:0]    CODE_STOP     = 7'h04;
   localparam logic [6:0]    CODE_OPER     = 7'h05;
   localparam logic [6:0]    CODE_PREOP    = 7'h7F;
   localparam logic [6:0]    CODE_BOOT     = 7'h00;
   localparam logic [7:0]    CS_START      = 8'h01;
   localparam logic [7:0]    CS_STOP       = 8'h02;
   localparam logic [7:0]    CS_PREOP      = 8'h80;
   localparam logic [7:0]    CS_RESET_NODE = 8'h81;
   localparam logic [7:0]    CS_RESET_COMM = 8'h82;
   localparam logic [15:0]   EMCY_LIFE     = 16'h8130;
   localparam logic [15:0]   EMCY_RPDO     = 16'h8250;
   localparam logic [7:0]    EMCY_ERR_REG  = 8'h11;
   localparam logic [3:0]    DLC_ONE       = 4'h1;
   localparam logic [3:0]    DLC_FULL      = 4'h8;
   localparam int            NPEND         = 5;
   localparam int            P_BOOT        = 0;
   localparam int            P_EMCY        = 1;
   localparam int            P_GUARD       = 2;
   localparam int            P_HB          = 3;
   localparam int            P_TPDO        = 4;

   typedef enum logic [1:0] {
      ST_BOOT  = 2'b00,
      ST_PREOP = 2'b01,
      ST_OPER  = 2'b10,
      ST_STOP  = 2'b11
   } nmt_state_t;
endpackage : canopen_guard_pkg

// ### canopen_node_guard_pdo_comm.sv
// node guarding, life guarding, heartbeat, one rx and one tx pdo
// assumes a frame-level can controller on sys_clk and an sdo layer for od access
`timescale 1ns/100ps
module canopen_node_guard_pdo_comm #(
   parameter int unsigned MS_CYCLES = canopen_guard_pkg::MS_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [6:0]  node_id,
   input  wire logic        rx_valid,
   input  wire logic [10:0] rx_id,
   input  wire logic        rx_rtr,
   input  wire logic [3:0]  rx_dlc,
   input  wire logic [63:0] rx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [10:0]      tx_id,
   output logic [3:0]       tx_dlc,
   output logic [63:0]      tx_data,
   input  wire logic        od_wr,
   input  wire logic        od_rd,
   input  wire logic [15:0] od_index,
   input  wire logic [7:0]  od_sub,
   input  wire logic [31:0] od_wdata,
   output logic             od_ack,
   output logic             od_abort,
   output logic [31:0]      od_rdata,
   output logic [1:0]       nmt_state,
   output logic             outputs_err,
   output logic             life_fault,
   input  wire logic [63:0] tpdo_in,
   input  wire logic [3:0]  tpdo_len,
   output logic             tpdo_rtr_req,
   input  wire logic        tpdo_rtr_reply,
   output logic [63:0]      rpdo_out,
   output logic             rpdo_new
);
   import canopen_guard_pkg::*;

   // ****************************************
   // pin sync and frame decode
   // ****************************************
   logic [6:0]   node_meta_ff;
   logic [6:0]   node_ff;
   nmt_state_t   state_ff;
   logic [6:0]   code;
   logic [10:0]  guard_id;
   logic         is_nmt;
   logic         nmt_cs_hit;
   logic         guard_req;
   logic         rpdo_hit;
   logic         tpdo_rtr;
   logic         nmt_reset;

   // node id is strapped off-chip, so it is resynchronised
   // no reset here: the pair flushes during reset, so the boot frame already carries the node id
   always_ff @(posedge sys_clk) begin
      node_meta_ff <= node_id;
      node_ff      <= node_meta_ff;
   end

   always_comb begin
      case (state_ff)
         ST_OPER:  code = CODE_OPER;
         ST_STOP:  code = CODE_STOP;
         ST_PREOP: code = CODE_PREOP;
         default:  code = CODE_BOOT;
      endcase
   end

   logic [31:0] rpdo_cob_ff;
   logic [31:0] tpdo_cob_ff;
   assign guard_id   = ID_GUARD_BASE + {4'h0, node_ff};
   assign is_nmt     = rx_valid && !rx_rtr && rx_id == ID_NMT && rx_dlc >= 4'h2;
   assign nmt_cs_hit = is_nmt && (rx_data[15:8] == 8'h00 || rx_data[14:8] == node_ff);
   assign nmt_reset  = nmt_cs_hit && (rx_data[7:0] == CS_RESET_NODE || rx_data[7:0] == CS_RESET_COMM);
   assign guard_req  = rx_valid && rx_rtr && rx_id == guard_id;
   assign rpdo_hit   = rx_valid && !rx_rtr && !rpdo_cob_ff[COB_VALID_BIT] && state_ff == ST_OPER
                       && rx_id == rpdo_cob_ff[ID_W-1:0];
   assign tpdo_rtr   = rx_valid && rx_rtr && !tpdo_cob_ff[COB_VALID_BIT] && state_ff == ST_OPER
                       && rx_id == tpdo_cob_ff[ID_W-1:0];

   // ****************************************
   // object dictionary
   // ****************************************
   logic [15:0] guard_interval_ff;
   logic [7:0]  life_multiplier_ff;
   logic [15:0] hb_time_ff;
   logic [15:0] rpdo_evt_ff;
   logic [15:0] tpdo_evt_ff;
   logic        cob_ok;
   logic        hit;
   logic [31:0] rd_mux;

   // extended ids are refused outright rather than truncated
   assign cob_ok = !od_wdata[COB_EXT_BIT];

   always_comb begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      if (od_index == IDX_GUARD && od_sub == 8'h00)
         rd_mux = {16'h0000, guard_interval_ff};
      else if (od_index == IDX_LIFE && od_sub == 8'h00)
         rd_mux = {24'h00_0000, life_multiplier_ff};
      else if (od_index == IDX_HEARTBEAT && od_sub == 8'h00)
         rd_mux = {16'h0000, hb_time_ff};
      else if (od_index == IDX_ERR_REG && od_sub == 8'h00)
         rd_mux = {30'h0000_0000, life_fault, outputs_err};
      else if (od_index == IDX_RPDO && od_sub == SUB_COBID)
         rd_mux = rpdo_cob_ff;
      else if (od_index == IDX_RPDO && od_sub == SUB_EVTIMER)
         rd_mux = {16'h0000, rpdo_evt_ff};
      else if (od_index == IDX_TPDO && od_sub == SUB_COBID)
         rd_mux = tpdo_cob_ff;
      else if (od_index == IDX_TPDO && od_sub == SUB_EVTIMER)
         rd_mux = {16'h0000, tpdo_evt_ff};
      else
         hit = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || nmt_reset) begin
         guard_interval_ff  <= 16'h0000;
         life_multiplier_ff <= 8'h00;
         hb_time_ff         <= 16'h0000;
         rpdo_cob_ff        <= COB_RESET;
         tpdo_cob_ff        <= COB_RESET;
         rpdo_evt_ff        <= 16'h0000;
         tpdo_evt_ff        <= 16'h0000;
      end else if (od_wr && hit) begin
         if (od_index == IDX_GUARD)
            guard_interval_ff <= od_wdata[15:0];
         if (od_index == IDX_LIFE)
            life_multiplier_ff <= od_wdata[7:0];
         if (od_index == IDX_HEARTBEAT)
            hb_time_ff <= od_wdata[15:0];
         if (od_index == IDX_RPDO && od_sub == SUB_COBID && cob_ok)
            rpdo_cob_ff <= od_wdata;
         if (od_index == IDX_TPDO && od_sub == SUB_COBID && cob_ok)
            tpdo_cob_ff <= od_wdata;
         if (od_index == IDX_RPDO && od_sub == SUB_EVTIMER)
            rpdo_evt_ff <= od_wdata[15:0];
         if (od_index == IDX_TPDO && od_sub == SUB_EVTIMER)
            tpdo_evt_ff <= od_wdata[15:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         od_ack   <= 1'b0;
         od_abort <= 1'b0;
         od_rdata <= 32'h0000_0000;
      end else begin
         od_ack   <= (od_wr || od_rd) && hit && !(od_wr && od_index == IDX_ERR_REG)
                     && !(od_wr && od_sub == SUB_COBID && !cob_ok);
         od_abort <= (od_wr || od_rd) && !(hit && !(od_wr && od_index == IDX_ERR_REG)
                     && !(od_wr && od_sub == SUB_COBID && !cob_ok));
         if (od_rd)
            od_rdata <= rd_mux;
      end
   end

   // ****************************************
   // millisecond tick and timers
   // ****************************************
   logic [15:0] div_ff;
   logic        ms_tick;
   logic [23:0] life_cnt_ff;
   logic        life_armed_ff;
   logic [23:0] life_time;
   logic        life_on;
   logic        life_expire;
   logic [15:0] hb_cnt_ff;
   logic        hb_due;
   logic [15:0] tevt_cnt_ff;
   logic        tevt_due;
   logic [15:0] revt_cnt_ff;
   logic        rwd_armed_ff;
   logic        rpdo_expire;
   logic [NPEND-1:0] pend_ff;
   logic [NPEND-1:0] grant;

   assign ms_tick = div_ff == 16'(MS_CYCLES - 1);

   always_ff @(posedge sys_clk) begin
      if (sys_rst || ms_tick)
         div_ff <= 16'h0000;
      else
         div_ff <= div_ff + 16'h0001;
   end

   assign life_time   = 24'(guard_interval_ff) * 24'(life_multiplier_ff);
   assign life_on     = guard_interval_ff != 16'h0000 && life_multiplier_ff != 8'h00;
   assign life_expire = life_on && life_armed_ff && ms_tick && life_cnt_ff + 24'h1 >= life_time;

   // watchdog arms on the first request, so a silent master never trips it
   always_ff @(posedge sys_clk) begin
      if (sys_rst || nmt_reset || !life_on) begin
         life_cnt_ff   <= 24'h00_0000;
         life_armed_ff <= 1'b0;
      end else if (guard_req) begin
         life_cnt_ff   <= 24'h00_0000;
         life_armed_ff <= 1'b1;
      end else if (life_expire) begin
         life_armed_ff <= 1'b0;
      end else if (ms_tick && life_armed_ff) begin
         life_cnt_ff <= life_cnt_ff + 24'h00_0001;
      end
   end

   assign hb_due = hb_time_ff != 16'h0000 && ms_tick && hb_cnt_ff + 16'h0001 >= hb_time_ff
                   && state_ff != ST_BOOT;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || hb_due || hb_time_ff == 16'h0000)
         hb_cnt_ff <= 16'h0000;
      else if (ms_tick)
         hb_cnt_ff <= hb_cnt_ff + 16'h0001;
   end

   assign tevt_due = tpdo_evt_ff != 16'h0000 && ms_tick && tevt_cnt_ff + 16'h0001 >= tpdo_evt_ff
                     && state_ff == ST_OPER && !tpdo_cob_ff[COB_VALID_BIT];

   always_ff @(posedge sys_clk) begin
      if (sys_rst || grant[P_TPDO] || state_ff != ST_OPER)
         tevt_cnt_ff <= 16'h0000;
      else if (ms_tick)
         tevt_cnt_ff <= tevt_cnt_ff + 16'h0001;
   end

   assign rpdo_expire = rpdo_evt_ff != 16'h0000 && rwd_armed_ff && ms_tick
                        && revt_cnt_ff + 16'h0001 >= rpdo_evt_ff;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || state_ff != ST_OPER || rpdo_cob_ff[COB_VALID_BIT]) begin
         revt_cnt_ff  <= 16'h0000;
         rwd_armed_ff <= 1'b1;
      end else if (rpdo_hit) begin
         revt_cnt_ff  <= 16'h0000;
         rwd_armed_ff <= 1'b1;
      end else if (rpdo_expire) begin
         rwd_armed_ff <= 1'b0;
      end else if (ms_tick && rwd_armed_ff) begin
         revt_cnt_ff <= revt_cnt_ff + 16'h0001;
      end
   end

   // ****************************************
   // nmt state and error flags
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst || nmt_reset)
         state_ff <= ST_BOOT;
      else if (state_ff == ST_BOOT && grant[P_BOOT])
         state_ff <= ST_PREOP;
      else if (life_expire && state_ff != ST_BOOT)
         state_ff <= ST_PREOP;
      else if (nmt_cs_hit && state_ff != ST_BOOT) begin
         case (rx_data[7:0])
            CS_START: state_ff <= ST_OPER;
            CS_STOP:  state_ff <= ST_STOP;
            CS_PREOP: state_ff <= ST_PREOP;
            default:  state_ff <= state_ff;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || nmt_reset) begin
         outputs_err <= 1'b0;
         life_fault  <= 1'b0;
      end else begin
         if (life_expire || rpdo_expire || (nmt_cs_hit && rx_data[7:0] == CS_STOP))
            outputs_err <= 1'b1;
         else if (nmt_cs_hit && rx_data[7:0] == CS_START)
            outputs_err <= 1'b0;
         if (life_expire)
            life_fault <= 1'b1;
         else if (guard_req)
            life_fault <= 1'b0;
      end
   end

   assign nmt_state = state_ff;

   // ****************************************
   // pdo data paths
   // ****************************************
   logic [63:0] tpdo_prev_ff;
   logic        tpdo_change;
   logic [15:0] emcy_code_ff;

   assign tpdo_change = tpdo_in != tpdo_prev_ff && state_ff == ST_OPER
                        && !tpdo_cob_ff[COB_VALID_BIT];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tpdo_prev_ff <= 64'h0000_0000_0000_0000;
         tpdo_rtr_req <= 1'b0;
         rpdo_out     <= 64'h0000_0000_0000_0000;
         rpdo_new     <= 1'b0;
      end else begin
         tpdo_prev_ff <= tpdo_in;
         tpdo_rtr_req <= tpdo_rtr;
         rpdo_new     <= rpdo_hit;
         if (rpdo_hit)
            rpdo_out <= rx_data;
      end
   end

   // ****************************************
   // transmit queue
   // ****************************************
   // one pending bit per message kind; lowest index wins the single slot
   always_comb begin
      grant = '0;
      for (int i = NPEND - 1; i >= 0; i--)
         if (pend_ff[i] && !tx_valid)
            grant = NPEND'(1) << i;
   end

   logic [NPEND-1:0] set_req;
   assign set_req[P_BOOT]  = state_ff == ST_BOOT && !pend_ff[P_BOOT] && !tx_valid;
   assign set_req[P_EMCY]  = life_expire || rpdo_expire;
   assign set_req[P_GUARD] = guard_req;
   assign set_req[P_HB]    = hb_due;
   assign set_req[P_TPDO]  = tpdo_change || tevt_due || tpdo_rtr_reply;

   // a new request in the grant cycle survives the clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst || nmt_reset)
         pend_ff <= '0;
      else
         pend_ff <= (pend_ff & ~grant) | set_req;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         emcy_code_ff <= 16'h0000;
      else if (life_expire)
         emcy_code_ff <= EMCY_LIFE;
      else if (rpdo_expire)
         emcy_code_ff <= EMCY_RPDO;
   end

   logic toggle_ff;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || nmt_reset)
         toggle_ff <= 1'b0;
      else if (grant[P_GUARD])
         toggle_ff <= ~toggle_ff;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_valid <= 1'b0;
         tx_id    <= 11'h000;
         tx_dlc   <= 4'h0;
         tx_data  <= 64'h0000_0000_0000_0000;
      end else if (tx_valid) begin
         if (tx_ready)
            tx_valid <= 1'b0;
      end else if (|grant) begin
         tx_valid <= 1'b1;
         tx_dlc   <= DLC_ONE;
         tx_id    <= guard_id;
         tx_data  <= '0;
         if (grant[P_GUARD])
            tx_data[7:0] <= {toggle_ff, code};
         else if (grant[P_HB])
            tx_data[7:0] <= {1'b0, code};
         else if (grant[P_EMCY]) begin
            tx_id   <= ID_EMCY_BASE + {4'h0, node_ff};
            tx_dlc  <= DLC_FULL;
            tx_data <= {40'h00_0000_0000, EMCY_ERR_REG, emcy_code_ff};
         end else if (grant[P_TPDO]) begin
            tx_id   <= tpdo_cob_ff[ID_W-1:0];
            tx_dlc  <= tpdo_len > DLC_FULL ? DLC_FULL : tpdo_len;
            tx_data <= tpdo_in;
         end
      end
   end
endmodule : canopen_node_guard_pdo_comm

// ### canopen_guard_monitor.sv
// assertions on the guarding, heartbeat and pdo block ports
// assumes it is bound to the design top and sees only its ports
`timescale 1ns/100ps
module canopen_guard_monitor #(
   parameter int unsigned MS_CYCLES = 10
) (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [6:0]  node_id,
   input wire logic        rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic        rx_rtr,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [3:0]  tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic        od_wr,
   input wire logic        od_rd,
   input wire logic [15:0] od_index,
   input wire logic [7:0]  od_sub,
   input wire logic [31:0] od_wdata,
   input wire logic        od_ack,
   input wire logic        od_abort,
   input wire logic [1:0]  nmt_state,
   input wire logic        outputs_err,
   input wire logic        life_fault
);
   import canopen_guard_pkg::*;
   // ************************
   // properties
   // ************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [10:0] gid;
   assign gid = ID_GUARD_BASE + {4'h0, node_id};
   sequence guard_req;
      rx_valid && rx_rtr && rx_id == gid;
   endsequence
   sequence guard_out;
      tx_valid && tx_id == gid && tx_dlc == DLC_ONE;
   endsequence
   hold_frame_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_id, tx_dlc, tx_data}))
      else $error("frame changed before accept");
   frame_len_a: assert property (tx_valid |-> tx_dlc <= DLC_FULL)
      else $error("frame longer than eight bytes");
   od_answer_a: assert property (od_wr || od_rd |=> od_ack != od_abort)
      else $error("object access not answered");
   ext_refused_a: assert property (od_wr && od_sub == SUB_COBID && (od_index == IDX_TPDO || od_index == IDX_RPDO)
      && od_wdata[COB_EXT_BIT] |=> od_abort)
      else $error("extended id accepted");
   guard_reply_a: assert property (guard_req |-> ##[1:60] guard_out)
      else $error("guard request not answered");
   oper_code_a: assert property (guard_out ##0 nmt_state == ST_OPER |-> tx_data[6:0] == CODE_OPER)
      else $error("wrong state code");
   life_state_a: assert property ($rose(life_fault) |-> ##[0:2] (outputs_err && nmt_state == ST_PREOP))
      else $error("life timeout without error state");
   life_clear_a: assert property (life_fault ##0 guard_req |-> ##[1:3] !life_fault)
      else $error("life fault not cleared");
   boot_msg_a: assert property ($fell(sys_rst) |-> ##[1:2] (guard_out ##0 tx_data[7:0] == 8'h00))
      else $error("no boot message");
endmodule : canopen_guard_monitor
bind canopen_node_guard_pdo_comm canopen_guard_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.sys_clk, .sys_rst,
   .node_id, .rx_valid, .rx_id, .rx_rtr, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .od_wr, .od_rd,
   .od_index, .od_sub, .od_wdata, .od_ack, .od_abort, .nmt_state, .outputs_err, .life_fault);

// ### can_master_model.sv
// frame-level network master facing the node
// assumes frames are handed over for one cycle at falling clock edges
`timescale 1ns/100ps
module can_master_model (
   input  wire logic        sys_clk,
   input  wire logic        tx_valid,
   input  wire logic [10:0] tx_id,
   input  wire logic [63:0] tx_data,
   output logic             rx_valid,
   output logic [10:0]      rx_id,
   output logic             rx_rtr,
   output logic [3:0]       rx_dlc,
   output logic [63:0]      rx_data,
   output logic             tx_ready
);
   logic        slow = 1'b0;
   logic        guard_pend = 1'b0;
   logic        exp_tog = 1'b0;
   logic [10:0] guard_id = 11'h7FF;
   int          faults = 0;
   initial begin
      {rx_valid, rx_rtr, tx_ready} = 3'h1;
      {rx_id, rx_dlc, rx_data} = '1;
   end
   always @(negedge sys_clk) begin
      tx_ready = slow ? 1'($urandom % 2) : 1'b1;
   end
   // ************************
   // frame traffic
   // ************************
   task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] data);
      @(negedge sys_clk);
      {rx_valid, rx_id, rx_rtr, rx_dlc, rx_data} = {1'b1, id, rtr, dlc, data};
      guard_pend = guard_pend | (rtr && id[10:8] == 3'h7);
      guard_id = id;
      @(negedge sys_clk);
      rx_valid = 1'b0;
      // released lines must not keep the old value
      {rx_id, rx_dlc, rx_data} = ~{id, dlc, data};
   endtask : send
   always @(posedge sys_clk) begin
      if (tx_valid && tx_ready && guard_pend && tx_id == guard_id) begin
         faults = faults + int'(tx_data[7] !== exp_tog);
         exp_tog = ~exp_tog;
         guard_pend = 1'b0;
      end
   end
endmodule : can_master_model

// ### canopen_node_guard_pdo_comm_bench.sv
// self-checking bench for the guarding, heartbeat and pdo block
// assumes the master model drives the can side, the bench the rest
`timescale 1ns/100ps
module canopen_node_guard_pdo_comm_bench;
   import canopen_guard_pkg::*;
   localparam logic [6:0]  NODE = 7'h1B;
   localparam logic [10:0] GID  = ID_GUARD_BASE + {4'h0, NODE};
   localparam logic [10:0] EID  = ID_EMCY_BASE + {4'h0, NODE};
   logic        sys_clk, sys_rst, rx_valid, rx_rtr, tx_valid, tx_ready, od_wr, od_rd, od_ack, od_abort;
   logic        outputs_err, life_fault, tpdo_rtr_req, tpdo_rtr_reply, rpdo_new, tog;
   logic [1:0]  nmt_state;
   logic [3:0]  rx_dlc, tx_dlc, tpdo_len;
   logic [6:0]  node_id;
   logic [7:0]  od_sub;
   logic [10:0] rx_id, tx_id;
   logic [15:0] od_index;
   logic [31:0] od_wdata, od_rdata;
   logic [33:0] ox;
   logic [63:0] rx_data, tx_data, tpdo_in, rpdo_out, rnd;
   logic [78:0] fq[$];
   logic [33:0] oq[$];
   logic [63:0] rq[$];
   int          err_total, checks, n;
   canopen_node_guard_pdo_comm #(.MS_CYCLES(10)) u_dut (.sys_clk, .sys_rst, .node_id, .rx_valid, .rx_id,
      .rx_rtr, .rx_dlc, .rx_data, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .od_wr, .od_rd, .od_index,
      .od_sub, .od_wdata, .od_ack, .od_abort, .od_rdata, .nmt_state, .outputs_err, .life_fault, .tpdo_in,
      .tpdo_len, .tpdo_rtr_req, .tpdo_rtr_reply, .rpdo_out, .rpdo_new);
   can_master_model u_mdl (.sys_clk, .tx_valid, .tx_id, .tx_data, .rx_valid, .rx_id, .rx_rtr, .rx_dlc,
      .rx_data, .tx_ready);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ************************
   // helpers
   // ************************
   task automatic cmp(input string what, input logic [78:0] exp, input logic [78:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic stop_test();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // bytes past the length are not compared
   function automatic logic [78:0] mask(input logic [78:0] f);
      return {f[78:64], f[63:0] & ((f[67:64] >= 4'h8) ? '1 : ~('1 << {f[67:64], 3'h0}))};
   endfunction : mask
   task automatic drain();
      int k;
      for (k = 0; k < 400 && fq.size() != 0; k++) @(negedge sys_clk);
      if (k == 400) begin
         cmp("frame wait", 0, fq.size());
         stop_test();
      end
   endtask : drain
   task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                     input logic ab);
      oq.push_back({ab, !wr, d});
      @(negedge sys_clk);
      {od_wr, od_rd, od_index, od_sub, od_wdata} = {wr, !wr, idx, sub, d};
      @(negedge sys_clk);
      {od_wr, od_rd} = 2'h0;
   endtask : od
   task automatic guard(input logic [6:0] code);
      fq.push_back({GID, DLC_ONE, 56'h0, tog, code});
      tog = ~tog;
      u_mdl.send(GID, 1'b1, 4'h0, 64'h0);
      drain();
   endtask : guard
   task automatic nmt(input logic [7:0] cs);
      u_mdl.send(ID_NMT, 1'b0, 4'h2, {48'h0, 1'b0, NODE, cs});
      repeat (2) @(negedge sys_clk);
   endtask : nmt
   always @(posedge sys_clk) begin
      if (!sys_rst && tx_valid && tx_ready)
         cmp("frame", mask(fq.size() ? fq.pop_front() : '1), mask({tx_id, tx_dlc, tx_data}));
      if (od_ack === 1'b1 || od_abort === 1'b1) begin
         ox = oq.size() ? oq.pop_front() : '1;
         cmp("od abort", ox[33], od_abort);
         if (ox[32])
            cmp("od rdata", ox[31:0], od_rdata);
      end
      if (rpdo_new === 1'b1)
         cmp("rpdo", rq.size() ? rq.pop_front() : '1, rpdo_out);
   end
   // ************************
   // main sequence
   // ************************
   initial begin
      rnd = 64'($urandom(81119));
      {sys_rst, node_id, od_wr, od_rd, od_index, od_sub, od_wdata} = {1'b1, NODE, 58'h0};
      {tpdo_in, tpdo_len, tpdo_rtr_reply, tog, err_total, checks} = {64'h0, 4'h8, 2'h0, 64'h0};
      repeat (4) @(negedge sys_clk);
      fq.push_back({GID, DLC_ONE, 64'h0});
      sys_rst = 1'b0;
      drain();
      u_mdl.slow = 1'b1;
      guard(CODE_PREOP);
      guard(CODE_PREOP);
      u_mdl.send(11'h701, 1'b0, 4'h1, 64'h05);
      od(1'b1, IDX_GUARD, 8'h00, 32'h2, 1'b0);
      od(1'b1, IDX_LIFE, 8'h00, 32'h3, 1'b0);
      od(1'b0, IDX_GUARD, 8'h00, 32'h2, 1'b0);
      od(1'b0, IDX_LIFE, 8'h00, 32'h3, 1'b0);
      od(1'b1, IDX_ERR_REG, 8'h00, 32'h0, 1'b1);
      od(1'b1, 16'h2000, 8'h00, 32'h0, 1'b1);
      od(1'b1, IDX_TPDO, SUB_COBID, 32'h2000_0181, 1'b1);
      od(1'b0, IDX_TPDO, SUB_COBID, COB_RESET, 1'b0);
      nmt(CS_START);
      cmp("state", ST_OPER, nmt_state);
      // spacing stays well inside the six ms life time even with a slow controller
      for (n = 0; n < 3; n++) begin
         repeat (30) @(negedge sys_clk);
         guard(CODE_OPER);
      end
      cmp("life fault", 1'b0, life_fault);
      fq.push_back({EID, DLC_FULL, 40'h0, EMCY_ERR_REG, EMCY_LIFE});
      drain();
      cmp("fault state", {3'h7, ST_PREOP}, {life_fault, outputs_err, 1'b1, nmt_state});
      guard(CODE_PREOP);
      cmp("life fault", 1'b0, life_fault);
      od(1'b1, IDX_LIFE, 8'h00, 32'h0, 1'b0);
      repeat (100) @(negedge sys_clk);
      cmp("life fault", 1'b0, life_fault);
      nmt(CS_START);
      cmp("outputs err", 1'b0, outputs_err);
      od(1'b1, IDX_TPDO, SUB_COBID, 32'h181, 1'b0);
      for (n = 0; n < 3; n++) begin
         rnd = {$urandom, $urandom};
         fq.push_back({11'h181, (n == 2) ? DLC_FULL : 4'(n + 3), rnd});
         @(negedge sys_clk);
         tpdo_in = rnd;
         tpdo_len = (n == 2) ? 4'hC : 4'(n + 3);
         drain();
      end
      u_mdl.send(11'h181, 1'b1, 4'h0, 64'h0);
      for (n = 0; n < 20 && tpdo_rtr_req !== 1'b1; n++) @(negedge sys_clk);
      cmp("rtr request", 1'b1, tpdo_rtr_req);
      if (tpdo_rtr_req !== 1'b1)
         stop_test();
      fq.push_back({11'h181, DLC_FULL, rnd});
      tpdo_rtr_reply = 1'b1;
      @(negedge sys_clk);
      tpdo_rtr_reply = 1'b0;
      drain();
      fq.push_back({11'h181, DLC_FULL, rnd});
      od(1'b1, IDX_TPDO, SUB_EVTIMER, 32'h3, 1'b0);
      drain();
      od(1'b1, IDX_TPDO, SUB_EVTIMER, 32'h0, 1'b0);
      od(1'b1, IDX_RPDO, SUB_COBID, 32'h8000_0201, 1'b0);
      u_mdl.send(11'h201, 1'b0, DLC_FULL, rnd);
      od(1'b1, IDX_RPDO, SUB_COBID, 32'h201, 1'b0);
      rnd = {$urandom, $urandom};
      rq.push_back(rnd);
      u_mdl.send(11'h201, 1'b0, DLC_FULL, rnd);
      fq.push_back({EID, DLC_FULL, 40'h0, EMCY_ERR_REG, EMCY_RPDO});
      od(1'b1, IDX_RPDO, SUB_EVTIMER, 32'h2, 1'b0);
      drain();
      cmp("outputs err", 1'b1, outputs_err);
      od(1'b1, IDX_RPDO, SUB_EVTIMER, 32'h0, 1'b0);
      nmt(CS_STOP);
      // a stalled controller would let a third beat in before the timer is switched off
      u_mdl.slow = 1'b0;
      fq.push_back({GID, DLC_ONE, 57'h0, CODE_STOP});
      fq.push_back({GID, DLC_ONE, 57'h0, CODE_STOP});
      od(1'b1, IDX_HEARTBEAT, 8'h00, 32'h1, 1'b0);
      drain();
      od(1'b1, IDX_HEARTBEAT, 8'h00, 32'h0, 1'b0);
      repeat (30) @(negedge sys_clk);
      cmp("left over", 0, fq.size() + oq.size() + rq.size());
      cmp("master faults", 0, u_mdl.faults);
      stop_test();
   end
endmodule : canopen_node_guard_pdo_comm_bench
